// File: design/dfcs_sequencer.sv
// Data-flash command sequencer: erase-verify section, program, erase sector.
// Assumes an array that answers reads one cycle later with data and ECC flags.
// How it works
// - erase-verify code 0x10, address, count at 010
// - check section erased, then set complete flag
// - erase-verify access errors on index, mode, address
// - erase-verify read errors set ECC status bits
// - program code 0x11, words at 010 to 101
// - word count follows index held at launch
// - program index outside 010..101 is access error
// - program bad, odd or overrunning address errors
// - protected area flags violation, stays untouched; sector erase checks only the sector base
// - program and erase verify set ECC bits
// - sector erase code 0x12, address in sector
// - sector erase clears sector, verifies, completes
// - sector erase access errors on index, address
// - clearing complete flag launches loaded command
// - command irq is complete flag and enable
// - error irq from enabled fault flags
// - read faults set double or single flags
// - wait mode does not disturb operation
// - stop granted only once command finishes
// - init holds flag low, ignores parameter writes
// - reset aborts a running command at once
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module dfcs_sequencer
	import dfcs_pkg::*;
#(
	parameter int WORDS  = 4096,
	parameter int SECTOR = 128
)(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	output var dfcs_arr_req_t        arrReq,
	input  wire logic [15:0]         arrRdata,
	input  wire logic                arrEccSingle,
	input  wire logic                arrEccDouble,
	input  wire logic                stopReq,
	output logic                     stopAck,
	output logic                     cmdIrq,
	output logic                     errIrq
);

	typedef enum logic [5:0] {
		S_INIT  = 6'h01,
		S_IDLE  = 6'h02,
		S_READ  = 6'h04,
		S_CHECK = 6'h08,
		S_WRITE = 6'h10,
		S_ERASE = 6'h20
	} dfcs_state_t;

	dfcs_state_t state_r;
	logic [2:0]  paramIndex_r;
	logic [15:0] param_r [0:5];
	logic        command_complete_flag_r, access_error_flag_r, pviol_r, eccAny_r, eccUnc_r;
	logic        command_complete_irq_enable_r, double_bit_fault_irq_enable_r, single_bit_fault_irq_enable_r, double_bit_fault_flag_r, single_bit_fault_flag_r;
	logic        modeOk_r;
	logic [15:0] protBase_r;
	logic [15:0] addr_r, remain_r, eraseCnt_r;
	logic [1:0]  wordSel_r;
	logic [$clog2(INIT_CYCLES+1)-1:0] initCnt_r;
	logic [31:0] rdata_r;
	logic        ack_r;

	logic [15:0] startAddr, wordCnt, lastAddr;
	logic [7:0]  cmdCode;
	logic        blockOk, launch, badAcc, protHit;
	logic        wrAcc, rdAcc;

	// Everything at or above the base address is protected.
	function automatic logic isProtected(input logic [15:0] a, input logic [15:0] base);
		isProtected = (a >= base);
	endfunction

	// Sector base: the low address bits inside one sector are dropped.
	function automatic logic [15:0] sectorBase(input logic [15:0] a);
		sectorBase = a & ~16'(SECTOR * 2 - 1);
	endfunction

	// Parameter slot that holds the program data of the selected word.
	function automatic logic [2:0] wordIndex(input logic [1:0] sel);
		wordIndex = 3'(IDX_COUNT + 3'(sel));
	endfunction

	// Writes act in the wait cycle; the master holds them through the next edge.
	assign wrAcc = avs_write & ~ack_r;
	assign rdAcc = avs_read & ~ack_r;
	// One wait cycle keeps read data coming from a flip-flop.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;

	assign cmdCode   = param_r[0][15:8];
	assign blockOk   = param_r[0][1:0] == DFLASH_BLOCK_SEL;
	assign startAddr = param_r[1];
	assign wordCnt   = (cmdCode == CMD_PROGRAM) ? 16'({13'h0, paramIndex_r} - 16'h1) : param_r[2];
	assign lastAddr  = 16'(startAddr + {wordCnt[14:0], 1'b0} - 16'h2);
	// Clearing the flag by writing one is what launches the loaded command.
	assign launch = wrAcc && avs_address == OFS_STATUS && avs_writedata[STAT_COMMAND_COMPLETE_FLAG]
		&& command_complete_flag_r && state_r == S_IDLE;

	// Launch checks; a bad command never reaches the array, it only flags.
	// Protection is judged on the last programmed word and on the sector base.
	always_comb
	begin
		badAcc = ~modeOk_r | ~blockOk | startAddr[0] | (32'(startAddr) >= 32'(WORDS * 2));
		protHit = 1'b0;
		case (cmdCode)
			CMD_ERASE_VERIFY_SECTION:
				badAcc = badAcc | paramIndex_r != IDX_COUNT | wordCnt == 16'h0
					| (32'(startAddr) + 32'(wordCnt) * 2 > 32'(WORDS * 2));
			CMD_PROGRAM:
			begin
				badAcc = badAcc | paramIndex_r < IDX_COUNT | paramIndex_r > IDX_LAST_WORD
					| (32'(startAddr) + 32'(wordCnt) * 2 > 32'(WORDS * 2));
				protHit = isProtected(lastAddr, protBase_r);
			end
			CMD_ERASE_SECTOR:
			begin
				badAcc = badAcc | paramIndex_r != IDX_ADDR;
				protHit = isProtected(sectorBase(startAddr), protBase_r);
			end
			default:
				badAcc = 1'b1;
		endcase
	end

	// The acknowledge toggles, so every request sees exactly one wait cycle.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read | avs_write) & ~ack_r;
	end

	// Read data is captured in the wait cycle and held until the next read.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_r <= 32'h0;
		else if (rdAcc)
		begin
			case (avs_address)
				OFS_PARAM_INDEX: rdata_r <= {29'h0, paramIndex_r};
				OFS_PARAM_WORD:  rdata_r <= (paramIndex_r <= IDX_LAST_WORD)
					? {16'h0, param_r[paramIndex_r]} : 32'h0;
				OFS_STATUS:      rdata_r <= {24'h0, command_complete_flag_r, 1'b0, access_error_flag_r, pviol_r,
					2'h0, eccAny_r, eccUnc_r};
				OFS_CONFIG:      rdata_r <= {24'h0, command_complete_irq_enable_r, 7'h0};
				OFS_ERR_STATUS:  rdata_r <= {30'h0, double_bit_fault_flag_r, single_bit_fault_flag_r};
				OFS_ERR_CONFIG:  rdata_r <= {30'h0, double_bit_fault_irq_enable_r, single_bit_fault_irq_enable_r};
				OFS_MODE:        rdata_r <= {31'h0, modeOk_r};
				OFS_PROTECT:     rdata_r <= {16'h0, protBase_r};
				default:         rdata_r <= 32'h0;
			endcase
		end
	end

	// Parameter writes are only honoured while idle with the flag set.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			paramIndex_r <= 3'h0;
			for (int i = 0; i < 6; i++)
				param_r[i] <= 16'h0;
		end
		else if (wrAcc && command_complete_flag_r && state_r == S_IDLE)
		begin
			if (avs_address == OFS_PARAM_INDEX)
				paramIndex_r <= avs_writedata[2:0];
			else if (avs_address == OFS_PARAM_WORD && paramIndex_r <= IDX_LAST_WORD)
				param_r[paramIndex_r] <= avs_writedata[15:0];
		end
	end

	// Configuration writes are honoured at any time, even while a command runs.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			command_complete_irq_enable_r <= 1'b0;
			double_bit_fault_irq_enable_r <= 1'b0;
			single_bit_fault_irq_enable_r <= 1'b0;
			modeOk_r <= 1'b1;
			protBase_r <= 16'hffff;
		end
		else if (wrAcc)
		begin
			if (avs_address == OFS_CONFIG)
				command_complete_irq_enable_r <= avs_writedata[7];
			if (avs_address == OFS_ERR_CONFIG)
			begin
				double_bit_fault_irq_enable_r <= avs_writedata[1];
				single_bit_fault_irq_enable_r <= avs_writedata[0];
			end
			if (avs_address == OFS_MODE)
				modeOk_r <= avs_writedata[0];
			if (avs_address == OFS_PROTECT)
				protBase_r <= avs_writedata[15:0];
		end
	end

	// Fault flags: a new fault wins over a write-one clear in the same cycle.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			double_bit_fault_flag_r <= 1'b0;
			single_bit_fault_flag_r <= 1'b0;
		end
		else
		begin
			if (state_r == S_CHECK && arrEccDouble)
				double_bit_fault_flag_r <= 1'b1;
			else if (wrAcc && avs_address == OFS_ERR_STATUS && avs_writedata[1])
				double_bit_fault_flag_r <= 1'b0;
			if (state_r == S_CHECK && arrEccSingle)
				single_bit_fault_flag_r <= 1'b1;
			else if (wrAcc && avs_address == OFS_ERR_STATUS && avs_writedata[0])
				single_bit_fault_flag_r <= 1'b0;
		end
	end

	// The sequencer; an asynchronous reset abandons any operation mid-way.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= S_INIT;
			command_complete_flag_r <= 1'b0;
			access_error_flag_r <= 1'b0;
			pviol_r <= 1'b0;
			eccAny_r <= 1'b0;
			eccUnc_r <= 1'b0;
			initCnt_r <= '0;
			addr_r <= 16'h0;
			remain_r <= 16'h0;
			eraseCnt_r <= 16'h0;
			wordSel_r <= 2'h0;
		end
		else
		begin
			case (state_r)
				S_INIT:
				begin
					// The flag stays low and parameter writes bounce until the count runs out.
					initCnt_r <= initCnt_r + 1'b1;
					if (32'(initCnt_r) == INIT_CYCLES - 1)
					begin
						command_complete_flag_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				S_IDLE:
				begin
					// Access and protection error bits clear by writing one; ECC bits clear at any launch, the complete flag only at an accepted one.
					if (wrAcc && avs_address == OFS_STATUS)
					begin
						if (avs_writedata[STAT_ACC])
							access_error_flag_r <= 1'b0;
						if (avs_writedata[STAT_PVIOL])
							pviol_r <= 1'b0;
					end
					if (launch)
					begin
						eccAny_r <= 1'b0;
						eccUnc_r <= 1'b0;
						wordSel_r <= 2'h0;
						addr_r <= startAddr;
						remain_r <= wordCnt;
						if (badAcc || (protHit && cmdCode != CMD_ERASE_VERIFY_SECTION))
						begin
							access_error_flag_r <= badAcc;
							pviol_r <= ~badAcc;
						end
						else
						begin
							command_complete_flag_r <= 1'b0;
							if (cmdCode == CMD_ERASE_SECTOR)
							begin
								addr_r <= sectorBase(startAddr);
								remain_r <= 16'(SECTOR);
								eraseCnt_r <= 16'(SECTOR);
								state_r <= S_ERASE;
							end
							else if (cmdCode == CMD_PROGRAM)
								state_r <= S_WRITE;
							else
								state_r <= S_READ;
						end
					end
				end
				S_WRITE:
				begin
					// All words go in first; the verify pass then rereads them from the start.
					addr_r <= addr_r + 16'h2;
					wordSel_r <= wordSel_r + 2'h1;
					remain_r <= remain_r - 16'h1;
					if (remain_r == 16'h1)
					begin
						addr_r <= startAddr;
						remain_r <= wordCnt;
						wordSel_r <= 2'h0;
						state_r <= S_READ;
					end
				end
				S_ERASE:
				begin
					// The whole sector is written erased, then verified like a section check.
					addr_r <= addr_r + 16'h2;
					eraseCnt_r <= eraseCnt_r - 16'h1;
					if (eraseCnt_r == 16'h1)
					begin
						addr_r <= sectorBase(startAddr);
						state_r <= S_READ;
					end
				end
				S_READ:
					state_r <= S_CHECK;
				S_CHECK:
				begin
					// Program checks the written value; the others check erased.
					if (arrEccSingle || arrEccDouble)
						eccAny_r <= 1'b1;
					if (arrEccDouble)
						eccUnc_r <= 1'b1;
					if (arrRdata != ((cmdCode == CMD_PROGRAM)
						? param_r[wordIndex(wordSel_r)] : ERASED_WORD))
						eccAny_r <= 1'b1;
					addr_r <= addr_r + 16'h2;
					wordSel_r <= wordSel_r + 2'h1;
					remain_r <= remain_r - 16'h1;
					state_r <= S_READ;
					if (remain_r == 16'h1)
					begin
						command_complete_flag_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				default:
					state_r <= S_INIT;
			endcase
		end
	end

	// The array request comes straight from the state: one word per cycle while writing, one word per two cycles while verifying.
	always_comb
	begin
		arrReq.addr = addr_r;
		arrReq.wdata = (state_r == S_ERASE) ? ERASED_WORD : param_r[wordIndex(wordSel_r)];
		arrReq.rd = state_r == S_READ;
		arrReq.wr = state_r == S_WRITE || state_r == S_ERASE;
	end

	// Stop is withheld while a command runs; wait mode has no effect here.
	assign stopAck = stopReq & command_complete_flag_r;
	assign cmdIrq = command_complete_flag_r & command_complete_irq_enable_r;
	assign errIrq = (double_bit_fault_flag_r & double_bit_fault_irq_enable_r) | (single_bit_fault_flag_r & single_bit_fault_irq_enable_r);

endmodule
`default_nettype wire

// File: include/dfcs_pkg.sv
// Package for the data-flash command sequencer: register map, codes, timing.
// Assumes a 32-bit Avalon-MM slave at 100 MHz and a byte-addressed data-flash array port of 16-bit words.
package dfcs_pkg;

	localparam logic [3:0]  OFS_PARAM_INDEX = 4'h0;
	localparam logic [3:0]  OFS_PARAM_WORD  = 4'h1;
	localparam logic [3:0]  OFS_STATUS      = 4'h2;
	localparam logic [3:0]  OFS_CONFIG      = 4'h3;
	localparam logic [3:0]  OFS_ERR_STATUS  = 4'h4;
	localparam logic [3:0]  OFS_ERR_CONFIG  = 4'h5;
	localparam logic [3:0]  OFS_MODE        = 4'h6;
	localparam logic [3:0]  OFS_PROTECT     = 4'h7;

	localparam logic [7:0]  CMD_ERASE_VERIFY_SECTION = 8'h10;
	localparam logic [7:0]  CMD_PROGRAM              = 8'h11;
	localparam logic [7:0]  CMD_ERASE_SECTOR         = 8'h12;

	localparam logic [2:0]  IDX_CMD       = 3'h0;
	localparam logic [2:0]  IDX_ADDR      = 3'h1;
	localparam logic [2:0]  IDX_COUNT     = 3'h2;
	localparam logic [2:0]  IDX_LAST_WORD = 3'h5;

	// Status bit positions.
	localparam int STAT_COMMAND_COMPLETE_FLAG  = 7;
	localparam int STAT_ACC   = 5;
	localparam int STAT_PVIOL = 4;
	localparam int STAT_ECC1  = 1;
	localparam int STAT_ECC0  = 0;

	localparam logic [1:0]  DFLASH_BLOCK_SEL = 2'h1;
	localparam logic [15:0] ERASED_WORD      = 16'hffff;

	localparam int INIT_TIME_NS = 1000;
	localparam int CLK_NS       = 10;
	localparam int INIT_CYCLES  = INIT_TIME_NS / CLK_NS;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        rd;
		logic        wr;
	} dfcs_arr_req_t;

endpackage

// File: testbench/dfcs_assertions.sv
// Port-level checker for the data-flash command sequencer.
// Assumes one clock domain; it is bound onto the sequencer below.
`timescale 1ns/1ps
`default_nettype none
module dfcs_assertions
	import dfcs_pkg::*;
#(
	parameter int WORDS  = 4096,
	parameter int SECTOR = 128
)(
	input wire logic          clk,
	input wire logic          rst,
	input wire logic [3:0]    avs_address,
	input wire logic          avs_read,
	input wire logic          avs_write,
	input wire logic [31:0]   avs_writedata,
	input wire logic [31:0]   avs_readdata,
	input wire logic          avs_waitrequest,
	input wire dfcs_arr_req_t arrReq,
	input wire logic [15:0]   arrRdata,
	input wire logic          arrEccSingle,
	input wire logic          arrEccDouble,
	input wire logic          stopReq,
	input wire logic          stopAck,
	input wire logic          cmdIrq,
	input wire logic          errIrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence reqRise;
		$rose(avs_read || avs_write);
	endsequence
	sequence oneWait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	bus_wait_a: assert property (reqRise |-> oneWait)
		else $error("waitrequest not exactly one cycle");
	stop_busy_a: assert property (arrReq.wr || arrReq.rd |-> !stopAck)
		else $error("stop granted while array busy");
	stop_req_a: assert property (stopAck |-> stopReq)
		else $error("stop granted without request");
	busy_irq_a: assert property (arrReq.wr || arrReq.rd |-> !cmdIrq)
		else $error("command irq while array busy");
	rd_check_a: assert property (arrReq.rd |=> !arrReq.rd)
		else $error("read not followed by check cycle");
	wr_range_a: assert property (arrReq.wr |-> arrReq.addr < WORDS * 2)
		else $error("array write past block end");
	init_low_a: assert property ($fell(rst) |-> (!cmdIrq && !stopAck) [*8])
		else $error("complete flag high during init");
	reset_quiet_a: assert property (disable iff (1'b0) rst |-> !cmdIrq && !errIrq)
		else $error("irq active in reset");
endmodule
bind dfcs_sequencer dfcs_assertions #(.WORDS(WORDS), .SECTOR(SECTOR)) dfcs_assertions_inst (
	.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .arrReq(arrReq), .arrRdata(arrRdata),
	.arrEccSingle(arrEccSingle), .arrEccDouble(arrEccDouble), .stopReq(stopReq),
	.stopAck(stopAck), .cmdIrq(cmdIrq), .errIrq(errIrq));
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the data-flash command sequencer.
// Assumes the bound checker; a small array model answers reads one cycle late.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dfcs_pkg::*;
	logic          clk = 1'b0, rst = 1'b1, eccD = 1'b0, eccS = 1'b0, stopReq = 1'b0;
	logic [3:0]    avs_address = 4'h0;
	logic          avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [31:0]   avs_writedata = 32'h0, avs_readdata, d;
	logic [15:0]   arrRdata = 16'h0, mem [4096];
	logic          stopAck, cmdIrq, errIrq;
	dfcs_arr_req_t arrReq;
	int            fail_count = 0, checked = 0, cyc = 0;
	initial forever #5 clk = ~clk;
	dfcs_sequencer #(.SECTOR(4)) dfcs_sequencer_inst (.clk(clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .arrReq(arrReq), .arrRdata(arrRdata),
		.arrEccSingle(eccS), .arrEccDouble(eccD), .stopReq(stopReq),
		.stopAck(stopAck), .cmdIrq(cmdIrq), .errIrq(errIrq));
	always @(posedge clk)
	begin
		if (arrReq.wr)
			mem[arrReq.addr[12:1]] <= arrReq.wdata;
		arrRdata <= mem[arrReq.addr[12:1]];
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fail_count++;
			final_report;
		end
	end
	task automatic final_report;
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	// An idle edge follows each transfer so a strobe is never driven twice at one edge.
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest) @(posedge clk);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdr(input logic [3:0] a);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest) @(posedge clk);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitDone;
		d = 32'h0;
		for (int i = 0; i < 300 && d[7] !== 1'b1; i++) rdr(OFS_STATUS);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [2:0] last, input logic [15:0] ad,
		input logic [15:0] cnt, input logic [7:0] st);
		wr(OFS_PARAM_INDEX, 32'h0);
		wr(OFS_PARAM_WORD, {16'h0, c, 8'h01});
		for (int i = 1; i <= last; i++)
		begin
			wr(OFS_PARAM_INDEX, i);
			wr(OFS_PARAM_WORD, i == 1 ? ad : (i == 2 && c == CMD_ERASE_VERIFY_SECTION) ?
				cnt : 16'ha500 + i[15:0]);
		end
		wr(OFS_STATUS, 32'h80);
		waitDone;
		chk(d & 32'hb3, st);
		wr(OFS_STATUS, 32'h30);
	endtask
	task automatic t_startup;
		rdr(OFS_STATUS);
		chk(d[7], 1'b0);
		wr(OFS_PARAM_INDEX, 32'h3);
		rdr(OFS_PARAM_INDEX);
		chk(d, 32'h0);
		rdr(4'h9);
		chk(d, 32'h0);
		stopReq <= 1'b1;
		waitDone;
		chk(stopAck, 1'b1);
		wr(OFS_CONFIG, 32'h80);
		chk(cmdIrq, 1'b1);
		wr(OFS_ERR_CONFIG, 32'h3);
	endtask
	task automatic t_program_erase;
		cmd(CMD_PROGRAM, 3, 16'h10, 0, 8'h80);
		chk(mem[8], 16'ha502);
		chk(mem[9], 16'ha503);
		chk(mem[10], 16'hffff);
		cmd(CMD_ERASE_VERIFY_SECTION, 2, 16'h10, 3, 8'h82);
		cmd(CMD_ERASE_SECTOR, 1, 16'h12, 0, 8'h80);
		chk(mem[9], 16'hffff);
		cmd(CMD_ERASE_VERIFY_SECTION, 2, 16'h10, 4, 8'h80);
	endtask
	task automatic t_access_errors;
		cmd(CMD_PROGRAM, 1, 16'h10, 0, 8'ha0);
		cmd(CMD_PROGRAM, 6, 16'h10, 0, 8'ha0);
		cmd(CMD_PROGRAM, 2, 16'h11, 0, 8'ha0);
		cmd(CMD_PROGRAM, 3, 16'h1ffe, 0, 8'ha0);
		cmd(CMD_ERASE_VERIFY_SECTION, 3, 16'h10, 1, 8'ha0);
		cmd(CMD_ERASE_SECTOR, 2, 16'h10, 0, 8'ha0);
		cmd(CMD_ERASE_SECTOR, 1, 16'h13, 0, 8'ha0);
		wr(OFS_MODE, 32'h0);
		cmd(CMD_PROGRAM, 2, 16'h10, 0, 8'ha0);
		wr(OFS_MODE, 32'h1);
	endtask
	task automatic t_protection;
		wr(OFS_PROTECT, 32'h20);
		cmd(CMD_PROGRAM, 2, 16'h20, 0, 8'h90);
		chk(mem[16], 16'hffff);
		cmd(CMD_ERASE_SECTOR, 1, 16'h24, 0, 8'h90);
		wr(OFS_PROTECT, 32'hffff);
	endtask
	task automatic t_ecc;
		eccD <= 1'b1;
		cmd(CMD_ERASE_VERIFY_SECTION, 2, 16'h10, 2, 8'h83);
		eccD <= 1'b0;
		chk(errIrq, 1'b1);
		rdr(OFS_ERR_STATUS);
		chk(d[1:0], 2'h2);
		wr(OFS_ERR_STATUS, 32'h3);
		chk(errIrq, 1'b0);
		eccS <= 1'b1;
		cmd(CMD_ERASE_VERIFY_SECTION, 2, 16'h10, 2, 8'h82);
		eccS <= 1'b0;
		chk(errIrq, 1'b1);
		rdr(OFS_ERR_STATUS);
		chk(d[1:0], 2'h1);
		wr(OFS_ERR_CONFIG, 32'h2);
		chk(errIrq, 1'b0);
		eccD <= 1'b1;
		cmd(CMD_PROGRAM, 2, 16'h40, 0, 8'h83);
		eccD <= 1'b0;
	endtask
	// A reset in the middle of a sector erase must stop the array at once.
	task automatic t_reset_abort;
		wr(OFS_PARAM_INDEX, 32'h0);
		wr(OFS_PARAM_WORD, {16'h0, CMD_ERASE_SECTOR, 8'h01});
		wr(OFS_PARAM_INDEX, 32'h1);
		wr(OFS_PARAM_WORD, 32'h40);
		wr(OFS_STATUS, 32'h80);
		chk(stopAck, 1'b0);
		rst <= 1'b1;
		@(posedge clk);
		chk(arrReq.wr, 1'b0);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdr(OFS_STATUS);
		chk(d[7], 1'b0);
		waitDone;
		chk(d & 32'hb3, 32'h80);
		chk(cmdIrq, 1'b0);
		wr(OFS_STATUS, 32'h0);
		rdr(OFS_STATUS);
		chk(d[7], 1'b1);
	endtask
	initial
	begin
		for (int i = 0; i < 4096; i++) mem[i] = 16'hffff;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_startup;
		t_program_erase;
		t_access_errors;
		t_protection;
		t_ecc;
		t_reset_abort;
		final_report;
	end
endmodule
`default_nettype wire
